// file: gdi_pkg.sv
// Package for the gate driver input control block: timing and enums.
// Assumes a 10 MHz reference clock shared by both ends.
package gdi_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Glitch limit in ns: pulses shorter than this never pass
  localparam int unsigned DEGLITCH_NS = 40;
  // Samples that must agree: one more than a sub-limit pulse can ever cover
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS - 1) / CLK_PERIOD_NS + 2;
  // Cycles the controller ignores the flag after a reset pulse, while it returns
  localparam int unsigned FLAG_SETTLE_CYC = DEGLITCH_CYC + 2;
  // Fault mute time in ns the controller waits before sending a reset pulse
  localparam int unsigned FAULT_MUTE_NS = 1_000;
  localparam int unsigned FAULT_MUTE_CYC = (FAULT_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the reset pulse the controller sends, in ns
  localparam int unsigned RESET_PULSE_NS = 500;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  typedef enum logic [1:0] {
    GDI_AUTO_NONE,
    GDI_AUTO_NONINV,
    GDI_AUTO_INV
  } gdi_auto_e;

  typedef enum logic [1:0] {
    GDI_CTL_IDLE,
    GDI_CTL_MUTE,
    GDI_CTL_PULSE
  } gdi_ctl_state_e;
endpackage : gdi_pkg

// file: gdi_if.sv
// Interface joining the driver input side and the controller.
// Open-drain flags carry level, drive and enable; the bench resolves wires.
interface gdi_if;
  logic pwm_noninv;
  logic pwm_inv;
  logic rst_en;
  logic fault_flag_n_o;
  logic fault_flag_n_oe;
  logic power_good_o;
  logic power_good_oe;
  logic fault_flag_n_i;
  logic power_good_i;

  modport device (
    input pwm_noninv, pwm_inv, rst_en,
    output fault_flag_n_o, fault_flag_n_oe, power_good_o, power_good_oe
  );
  modport ctrl (
    output pwm_noninv, pwm_inv, rst_en,
    input fault_flag_n_i, power_good_i
  );
endinterface : gdi_if

// file: gdi_device.sv
// Input side logic of an isolated single channel gate driver.
// Assumes pins arrive asynchronously; open-drain flags are resolved outside.
module gdi_deglitch
  import gdi_pkg::*;
#(
  parameter int unsigned LEN = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic raw_in,
  output logic clean_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [CNT_W-1:0] cnt;
    logic clean;
  } gdi_dg_s;
  gdi_dg_s cur;
  gdi_dg_s nxt;
  // The counter is CNT_W bits wide; a longer filter would wrap and pass glitches
  if (LEN < 1 || LEN > (2 ** CNT_W) - 1)
  begin : g_len_check
    $error("deglitch length out of range");
  end
  always_comb
  begin
    nxt = cur;
    nxt.s1 = raw_in;
    nxt.s2 = cur.s1;
    // A level must persist LEN cycles before it is accepted
    if (cur.s2 == cur.clean)
    begin
      nxt.cnt = '0;
    end
    else if (cur.cnt >= CNT_W'(LEN - 1))
    begin
      nxt.clean = cur.s2;
      nxt.cnt = '0;
    end
    else
    begin
      nxt.cnt = cur.cnt + CNT_W'(1);
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= nxt;
    end
  end
  assign clean_out = cur.clean;
endmodule : gdi_deglitch

// Function
// (RQ1) Pulses under 40ns never change state
// (RQ2) Both PWM inputs high forces output low
// (RQ3) Controller never floats inputs; unused inverting grounded
// (RQ4) Half bridge: complementary PWM to inverting input
// (RQ5) Fault and power-good flags are open-drain
// (RQ6) Reset/enable low disables; default pulled disabled
// (RQ7) Overcurrent latches fault flag and output low
// (RQ8) Low reset/enable level clears latched fault
// (RQ9) Controller waits fault mute time before reset; code waits in NONE mode only, auto modes pass PWM to reset/enable
// (RQ10) Auto reset: non-inverting PWM drives reset/enable
// (RQ11) Auto reset inverting: invert PWM into reset/enable
// (RQ12) Output high only when all conditions allow
module gdi_device
  import gdi_pkg::*;
#(
  parameter int unsigned DG_LEN = DEGLITCH_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  gdi_if.device link,
  input wire logic overcurrent_in,
  input wire logic supply_ok_in,
  output logic gate_source_out,
  output logic gate_sink_out,
  output logic fault_latched_out
);
  typedef struct packed {
    logic fault;
    logic gate_on;
    logic gate_off;
    logic oc_s1;
    logic oc_s2;
    logic ok_s1;
    logic ok_s2;
  } gdi_dev_s;
  gdi_dev_s cur;
  gdi_dev_s next_cur;
  logic in_p;
  logic in_n;
  logic rst_en;

  // A shorter filter could let one stray sample of a short pulse through
  if (DG_LEN < DEGLITCH_CYC)
  begin : g_len_short
    $error("deglitch length too short for the glitch limit");
  end
  if (DG_LEN > (2 ** CNT_W) - 1)
  begin : g_len_long
    $error("deglitch length too long for the filter counter");
  end

  // Each reason to hold the gate low has a branch, fault and overcurrent sharing one; low is the safe answer
  function automatic logic gate_permit(
    input logic p,
    input logic n,
    input logic en,
    input logic fault_flag_n,
    input logic ok,
    input logic oc
  );
    logic permit;
    permit = 1'b1;
    if (p && n)
    begin
      permit = 1'b0; // see (RQ2)
    end
    else if (!en)
    begin
      permit = 1'b0; // see (RQ6)
    end
    else if (fault_flag_n || oc)
    begin
      permit = 1'b0; // see (RQ7)
    end
    else if (!ok)
    begin
      // An undervoltage supply would leave the switch poorly enhanced
      permit = 1'b0;
    end
    else if (!p || n)
    begin
      permit = 1'b0; // see (RQ12)
    end
    return permit;
  endfunction : gate_permit

  gdi_deglitch #(.LEN(DG_LEN)) u_dg_p ( // see (RQ1)
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .raw_in(link.pwm_noninv),
    .clean_out(in_p)
  );
  gdi_deglitch #(.LEN(DG_LEN)) u_dg_n ( // see (RQ1)
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .raw_in(link.pwm_inv),
    .clean_out(in_n)
  );
  gdi_deglitch #(.LEN(DG_LEN)) u_dg_r ( // see (RQ1)
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .raw_in(link.rst_en),
    .clean_out(rst_en)
  );

  always_comb
  begin
    next_cur = cur;
    next_cur.oc_s1 = overcurrent_in;
    next_cur.oc_s2 = cur.oc_s1;
    next_cur.ok_s1 = supply_ok_in;
    next_cur.ok_s2 = cur.ok_s1;
    // Detection wins over a simultaneous reset so no event is lost
    if (cur.oc_s2)
    begin
      next_cur.fault = 1'b1; // see (RQ7)
    end
    else if (!rst_en)
    begin
      next_cur.fault = 1'b0; // see (RQ8)
    end
    next_cur.gate_on = gate_permit(in_p, in_n, rst_en, next_cur.fault, cur.ok_s2, cur.oc_s2);
    // Sink gets its own flop so both output stages switch on the same edge
    next_cur.gate_off = !next_cur.gate_on;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      // Reset pulls the gate low through the sink stage
      cur <= '{fault: 1'b0, gate_on: 1'b0, gate_off: 1'b1, oc_s1: 1'b0, oc_s2: 1'b0,
        ok_s1: 1'b0, ok_s2: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign gate_source_out = cur.gate_on;
  assign gate_sink_out = cur.gate_off;
  assign fault_latched_out = cur.fault;
  // Open drain: only ever pull low, otherwise release
  assign link.fault_flag_n_o = 1'b0; // see (RQ5)
  assign link.fault_flag_n_oe = cur.fault; // see (RQ5) (RQ7)
  assign link.power_good_o = 1'b0; // see (RQ5)
  assign link.power_good_oe = !cur.ok_s2; // see (RQ5)
endmodule : gdi_device

// file: gdi_ctrl.sv
// Controller end: drives PWM and reset/enable, watches the fault flag.
// Assumes the flag wires are resolved outside with a pullup.
module gdi_ctrl
  import gdi_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  gdi_if.ctrl link,
  input wire logic pwm_top_in,
  input wire logic pwm_comp_in,
  input wire logic enable_in,
  input wire gdi_pkg::gdi_auto_e auto_mode_in,
  output logic fault_seen_out,
  output logic power_good_out
);
  typedef struct packed {
    gdi_ctl_state_e st;
    logic [CNT_W-1:0] cnt;
    logic f1;
    logic f2;
    logic g1;
    logic g2;
    logic pwm_p;
    logic pwm_n;
    logic rst_en;
  } gdi_ctl_s;
  gdi_ctl_s cur;
  gdi_ctl_s next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.f1 = link.fault_flag_n_i;
    next_cur.f2 = cur.f1;
    next_cur.g1 = link.power_good_i;
    next_cur.g2 = cur.g1;
    next_cur.pwm_p = pwm_top_in;
    next_cur.pwm_n = pwm_comp_in; // see (RQ3) (RQ4)
    case (cur.st)
      GDI_CTL_IDLE:
      begin
        // Let a cleared flag travel back before judging it again
        if (cur.cnt != '0)
        begin
          next_cur.cnt = cur.cnt - CNT_W'(1);
        end
        else if (!cur.f2)
        begin
          next_cur.st = GDI_CTL_MUTE;
        end
      end
      GDI_CTL_MUTE:
      begin
        if (cur.cnt >= CNT_W'(FAULT_MUTE_CYC - 1))
        begin
          next_cur.st = GDI_CTL_PULSE; // see (RQ9)
          next_cur.cnt = '0;
        end
        else
        begin
          next_cur.cnt = cur.cnt + CNT_W'(1);
        end
      end
      default:
      begin
        if (cur.cnt >= CNT_W'(RESET_PULSE_CYC - 1))
        begin
          next_cur.st = GDI_CTL_IDLE;
          next_cur.cnt = CNT_W'(FLAG_SETTLE_CYC);
        end
        else
        begin
          next_cur.cnt = cur.cnt + CNT_W'(1);
        end
      end
    endcase
    case (auto_mode_in)
      GDI_AUTO_NONINV: next_cur.rst_en = pwm_top_in; // see (RQ10)
      GDI_AUTO_INV: next_cur.rst_en = !pwm_comp_in; // see (RQ11)
      default: next_cur.rst_en = enable_in && (next_cur.st != GDI_CTL_PULSE); // see (RQ9)
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cur <= '{st: GDI_CTL_IDLE, cnt: '0, f1: 1'b1, f2: 1'b1, g1: 1'b1, g2: 1'b1,
        pwm_p: 1'b0, pwm_n: 1'b0, rst_en: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign link.pwm_noninv = cur.pwm_p;
  assign link.pwm_inv = cur.pwm_n;
  assign link.rst_en = cur.rst_en;
  assign fault_seen_out = !cur.f2;
  assign power_good_out = cur.g2;
endmodule : gdi_ctrl

// file: gdi_chk.sv
// Checker on the link between driver and controller.
// Assumes one clock and an active low async reset.
module gdi_chk (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic pwm_noninv,
  input wire logic pwm_inv,
  input wire logic rst_en,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe,
  input wire logic power_good_o,
  input wire logic gate_on_in
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Cycles since reset/enable was last low, saturating
  logic [3:0] since_low;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      since_low <= 4'hF;
    else if (!rst_en)
      since_low <= 4'h0;
    else if (since_low != 4'hF)
      since_low <= since_low + 4'h1;
  end
  AST_FLT_OD: assert property (fault_flag_n_o == 1'b0)
    else $error("fault flag drives high");
  AST_RDY_OD: assert property (power_good_o == 1'b0)
    else $error("power good drives high");
  AST_FLT_HOLD: assert property ($fell(fault_flag_n_oe) |-> since_low <= 4'h6)
    else $error("fault cleared without reset");
  // Sync and filter latency stays below seven cycles at the default clock
  AST_INTERLOCK: assert property ((pwm_noninv && pwm_inv) [*7] |-> !gate_on_in)
    else $error("gate on while both inputs high");
  AST_DISABLED: assert property ((!rst_en) [*7] |-> !gate_on_in)
    else $error("gate on while disabled");
  AST_FLT_GATE: assert property (fault_flag_n_oe |-> !gate_on_in)
    else $error("gate on while fault latched");
  cover property ($rose(fault_flag_n_oe));
  cover property ($fell(fault_flag_n_oe));
  cover property (pwm_noninv && pwm_inv && rst_en);
endmodule : gdi_chk

// file: gate_driver_input_control_tb.sv
// Bench joining driver and controller ends through the link.
// Flag wires are resolved here with a pullup.
module gate_driver_input_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gdi_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic oc = 1'b0, sup = 1'b0, top = 1'b0, comp = 1'b0, en = 1'b0;
  gdi_auto_e mode = GDI_AUTO_NONE;
  logic gsrc, gsnk, flat, fseen, pgood, g;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] rnd = 32'h5582;
  gdi_if link ();
  assign link.fault_flag_n_i = link.fault_flag_n_oe ? link.fault_flag_n_o : 1'b1;
  assign link.power_good_i = link.power_good_oe ? link.power_good_o : 1'b1;
  gdi_device u_gdi_device (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .link(link.device), .overcurrent_in(oc), .supply_ok_in(sup),
    .gate_source_out(gsrc), .gate_sink_out(gsnk), .fault_latched_out(flat));
  gdi_ctrl u_gdi_ctrl (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .link(link.ctrl), .pwm_top_in(top), .pwm_comp_in(comp), .enable_in(en),
    .auto_mode_in(mode), .fault_seen_out(fseen), .power_good_out(pgood));
  gdi_chk u_gdi_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .pwm_noninv(link.pwm_noninv), .pwm_inv(link.pwm_inv), .rst_en(link.rst_en),
    .fault_flag_n_o(link.fault_flag_n_o), .fault_flag_n_oe(link.fault_flag_n_oe),
    .power_good_o(link.power_good_o), .gate_on_in(gsrc));
`define CHK(nm, e, v) begin cmp_count++; if ((v) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %b seen %b", nm, e, v); end end
  initial
  begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr
  function automatic logic gexp(input logic p, c, e, s, gdi_auto_e m);
    logic eff;
    eff = (m == GDI_AUTO_NONE) ? e : (m == GDI_AUTO_NONINV) ? p : !c;
    return p & !c & eff & s;
  endfunction : gexp
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask : tick
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Polls the latch; a limit that runs out ends the run
  task automatic wait_clear(input int lim);
    for (int i = 0; i < lim && flat !== 1'b0; i++)
      tick(1);
    if (flat !== 1'b0)
    begin
      n_errors++;
      $display("ERROR fault clear timeout");
      summarize();
    end
  endtask : wait_clear
  // Fault then clear, by pulse in NONE mode or by PWM low in NONINV mode
  task automatic fault_run(input gdi_auto_e m);
    @(posedge ref_clk_in);
    {top, comp, en, sup, mode} <= {4'hB, m};
    tick(8);
    @(posedge ref_clk_in);
    oc <= 1'b1;
    tick(2);
    @(posedge ref_clk_in);
    oc <= 1'b0;
    tick(8);
    `CHK("latched", 1'b1, flat)
    `CHK("gate", 1'b0, gsrc)
    `CHK("seen", 1'b1, fseen)
    if (m == GDI_AUTO_NONINV)
    begin
      @(posedge ref_clk_in);
      top <= 1'b0;
      tick(6);
      @(posedge ref_clk_in);
      top <= 1'b1;
    end
    wait_clear(60);
    tick(8);
    `CHK("gate", 1'b1, gsrc)
    $display("test fault mode %0d done", m);
  endtask : fault_run
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    tick(2);
    for (int i = 0; i < 60; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge ref_clk_in);
      // First two: interlock, then plain drive
      if (i < 2)
        {top, comp, en, sup} <= (i == 0) ? 4'hF : 4'hB;
      else
        {top, comp, en, sup} <= {rnd[0], rnd[1], rnd[2] | rnd[3], rnd[4] | rnd[5]};
      mode <= gdi_auto_e'(i % 3);
      tick(8);
      g = gexp(top, comp, en, sup, mode);
      `CHK("gate", g, gsrc)
      `CHK("sink", ~g, gsnk)
      `CHK("pgood", sup, pgood)
      `CHK("inv", comp, link.pwm_inv)
      if (mode == GDI_AUTO_NONINV)
        `CHK("rst_en", top, link.rst_en)
      if (mode == GDI_AUTO_INV)
        `CHK("rst_en", ~comp, link.rst_en)
    end
    $display("test random levels done");
    fault_run(GDI_AUTO_NONE);
    fault_run(GDI_AUTO_NONINV);
    summarize();
  end
endmodule : gate_driver_input_control_tb
